//--- verilog/sim_seq_pkg.sv
/*
  Shared constants of the interrupt sequencer: register offsets, bit
  positions, event bits, reset values and one-hot states.
  Assumes an 8-bit register port with a 3-bit word address.
*/
package sim_seq_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 3;
  localparam int VEC_W   = 16;
  localparam int NUM_EVT = 4;
  localparam int SRCN_W  = 4;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS1 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS2 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS3 = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_EVENT   = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_EVMASK  = 3'h4;

  // Request index inside the source vectors
  localparam int IDX_SRC1  = 0;
  localparam int IDX_SRC3  = 1;
  localparam int IDX_SRC4  = 2;
  localparam int IDX_SRC5  = 3;
  localparam int IDX_SRC14 = 4;
  localparam int IDX_SRC15 = 5;

  // Bit positions inside the status registers
  localparam int POS_SRC1  = 2;
  localparam int POS_SRC3  = 4;
  localparam int POS_SRC4  = 5;
  localparam int POS_SRC5  = 6;
  localparam int POS_SRC14 = 7;
  localparam int POS_SRC15 = 0;

  // Event bits
  localparam int EVT_ENTRY = 0;
  localparam int EVT_CHAIN = 1;
  localparam int EVT_WAKE  = 2;
  localparam int EVT_RESET = 3;

  localparam logic [NUM_EVT-1:0] EVMASK_RST = 4'h0;
  localparam logic [DATA_W-1:0]  READ_ZERO  = 8'h00;

  // Source number of each request index, lowest index wins arbitration
  function automatic logic [SRCN_W-1:0] src_number(input int idx);
    case (idx)
      IDX_SRC1:  src_number = 4'h1;
      IDX_SRC3:  src_number = 4'h3;
      IDX_SRC4:  src_number = 4'h4;
      IDX_SRC5:  src_number = 4'h5;
      IDX_SRC14: src_number = 4'hE;
      default:   src_number = 4'hF;
    endcase
  endfunction : src_number

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_IDLE     = 16'h0001,
    ST_DUMMY    = 16'h0002,
    ST_PUSH_PCL = 16'h0004,
    ST_PUSH_PCH = 16'h0008,
    ST_PUSH_X   = 16'h0010,
    ST_PUSH_A   = 16'h0020,
    ST_PUSH_CCR = 16'h0040,
    ST_VECT_HI  = 16'h0080,
    ST_VECT_LO  = 16'h0100,
    ST_FETCH    = 16'h0200,
    ST_PULL_CCR = 16'h0400,
    ST_PULL_A   = 16'h0800,
    ST_PULL_X   = 16'h1000,
    ST_PULL_PCH = 16'h2000,
    ST_PULL_PCL = 16'h4000,
    ST_PREFETCH = 16'h8000
  } seq_state_type;

endpackage : sim_seq_pkg

//--- verilog/fixed_priority_pick.sv
/*
  Fixed priority picker: lowest set index wins.
  Combinational; assumes requests from the same clock.
*/
`timescale 1ns/10ps
module fixed_priority_pick #(
  parameter int N     = 6,
  parameter int IDX_W = 3
) (
  input  wire logic [N-1:0]     req_i,   // Candidate requests
  output logic                  any_o,   // At least one request
  output logic      [IDX_W-1:0] idx_o    // Winning index
);

  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = IDX_W'(i);
      end
    end
  end

endmodule : fixed_priority_pick

//--- verilog/event_flags.sv
/*
  Sticky write-one-to-clear event flags, mask and level interrupt.
  Assumes set pulses and write strobes on the same clock.
*/
`timescale 1ns/10ps
module event_flags #(
  parameter int                N        = 4,
  parameter logic [N-1:0]      MASK_RST = '0
) (
  input  wire logic          clk_i,       // Clock
  input  wire logic          rst_i,       // Synchronous reset
  input  wire logic [N-1:0]  set_i,       // Event pulses
  input  wire logic          clr_wr_i,    // Write to status
  input  wire logic          mask_wr_i,   // Write to mask
  input  wire logic [N-1:0]  data_i,      // Write data
  output logic      [N-1:0]  status_o,    // Sticky flags
  output logic      [N-1:0]  mask_o,      // Enable mask
  output logic               irq_o        // Level interrupt
);

  wire [N-1:0] clr_bits    = clr_wr_i ? data_i : '0;
  // A set in the clearing cycle survives
  wire [N-1:0] next_status = (status_o & ~clr_bits) | set_i;
  wire [N-1:0] next_mask   = mask_wr_i ? data_i : mask_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      mask_o   <= MASK_RST;
      irq_o    <= 1'b0;
    end else begin
      status_o <= next_status;
      mask_o   <= next_mask;
      irq_o    <= |(next_status & next_mask);
    end
  end

endmodule : event_flags

//--- verilog/sim_interrupt_sequencer.sv
/*
  Interrupt sequencer: boundary decisions, stacking, vector and return
  steps, and three request status registers.
  Assumes instr_done_i or rti_exec_i pulses at each instruction end, all
  inputs on ref_clk_i.
*/
// Overview of operation
// - Interrupts start only after current instruction ends
// - Take when mask clear and source enabled
// - Lowest index source wins among pending
// - Pending request after return enters immediately
// - Return always prefetches the following opcode, even when a pending request chains
// - High index register never stacked on entry
// - Status one shows sources 1,3,4,5 only
// - Status two shows only source 14
// - Status three shows only source 15
// - All reset sources equal, above interrupts
// - Wait or stop clears core mask
`timescale 1ns/10ps
module sim_interrupt_sequencer #(
  parameter int                           RST_W      = 4,
  parameter logic [sim_seq_pkg::VEC_W-1:0] VECTOR_TOP = 16'hFFFE
) (
  input  wire logic                                ref_clk_i,       // 100 MHz clock
  input  wire logic                                sys_rst_i,       // Sync reset, high
  input  wire logic [sim_seq_pkg::ADDR_W-1:0]      addr_i,          // Register address
  input  wire logic [sim_seq_pkg::DATA_W-1:0]      wr_data_i,       // Write data
  input  wire logic                                wr_en_i,         // Write strobe
  input  wire logic                                rd_en_i,         // Read strobe
  output logic      [sim_seq_pkg::DATA_W-1:0]      rd_data_o,       // Read data
  input  wire logic [sim_seq_pkg::NUM_SRC-1:0]     irq_req_i,       // Peripheral requests
  input  wire logic [sim_seq_pkg::NUM_SRC-1:0]     irq_en_i,        // Source enables
  input  wire logic                                core_mask_i,     // Core mask bit
  input  wire logic                                instr_done_i,    // Instruction boundary
  input  wire logic                                rti_exec_i,      // Return ends
  input  wire logic                                lowpower_exec_i, // Wait or stop
  input  wire logic [RST_W-1:0]                    reset_src_i,     // Reset sources
  output logic                                     core_reset_o,    // Core reset
  output logic                                     core_hold_o,     // Sequence running
  output sim_seq_pkg::seq_state_type               bus_step_o,      // Current bus step
  output logic      [sim_seq_pkg::VEC_W-1:0]       vector_addr_o,   // Vector byte address
  output logic      [sim_seq_pkg::SRCN_W-1:0]      grant_src_o,     // Serviced source
  output logic                                     mask_set_o,      // Set core mask
  output logic                                     mask_clear_o,    // Clear core mask
  output logic                                     fetch_next_o,    // Fetch next opcode
  output logic                                     irq_o            // Event interrupt
);

  localparam int IDX_W = $clog2(sim_seq_pkg::NUM_SRC);

  // ---------------------------------------------------------------
  // Request evaluation
  // ---------------------------------------------------------------
  logic [sim_seq_pkg::NUM_SRC-1:0] candidate;
  logic                            cand_any;
  logic [IDX_W-1:0]                cand_idx;
  logic                            take_irq;
  logic                            any_reset;

  assign candidate = irq_req_i & irq_en_i;
  assign take_irq  = cand_any & ~core_mask_i;
  assign any_reset = |reset_src_i;

  fixed_priority_pick #(
    .N     (sim_seq_pkg::NUM_SRC),
    .IDX_W (IDX_W)
  ) u_pick (
    .req_i (candidate),
    .any_o (cand_any),
    .idx_o (cand_idx)
  );

  logic [sim_seq_pkg::SRCN_W-1:0] cand_src;
  logic [sim_seq_pkg::VEC_W-1:0]  cand_vector;

  assign cand_src    = sim_seq_pkg::src_number(int'(cand_idx));
  // Two bytes per vector, counting down from the top
  assign cand_vector = VECTOR_TOP
                     - sim_seq_pkg::VEC_W'({cand_src, 1'b0});

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  sim_seq_pkg::seq_state_type state;
  sim_seq_pkg::seq_state_type next_state;
  logic                       start_entry;
  logic                       chain_entry;
  logic                       next_fetch;

  assign start_entry = (state == sim_seq_pkg::ST_IDLE) & instr_done_i
                     & ~rti_exec_i & take_irq;
  assign chain_entry = (state == sim_seq_pkg::ST_PREFETCH) & take_irq;
  assign next_fetch  = ((state == sim_seq_pkg::ST_IDLE) & instr_done_i
                        & ~rti_exec_i & ~take_irq)
                     | ((state == sim_seq_pkg::ST_PREFETCH) & ~take_irq);

  always_comb begin
    next_state = state;
    case (state)
      sim_seq_pkg::ST_IDLE: begin
        if (rti_exec_i) begin
          next_state = sim_seq_pkg::ST_PULL_CCR;
        end else if (start_entry) begin
          next_state = sim_seq_pkg::ST_DUMMY;
        end
      end

      sim_seq_pkg::ST_DUMMY:
        next_state = sim_seq_pkg::ST_PUSH_PCL;

      sim_seq_pkg::ST_PUSH_PCL:
        next_state = sim_seq_pkg::ST_PUSH_PCH;

      sim_seq_pkg::ST_PUSH_PCH:
        next_state = sim_seq_pkg::ST_PUSH_X;

      sim_seq_pkg::ST_PUSH_X:
        next_state = sim_seq_pkg::ST_PUSH_A;

      sim_seq_pkg::ST_PUSH_A:
        next_state = sim_seq_pkg::ST_PUSH_CCR;

      sim_seq_pkg::ST_PUSH_CCR:
        next_state = sim_seq_pkg::ST_VECT_HI;

      sim_seq_pkg::ST_VECT_HI:
        next_state = sim_seq_pkg::ST_VECT_LO;

      sim_seq_pkg::ST_VECT_LO:
        next_state = sim_seq_pkg::ST_FETCH;

      sim_seq_pkg::ST_FETCH:
        next_state = sim_seq_pkg::ST_IDLE;

      sim_seq_pkg::ST_PULL_CCR:
        next_state = sim_seq_pkg::ST_PULL_A;

      sim_seq_pkg::ST_PULL_A:
        next_state = sim_seq_pkg::ST_PULL_X;

      sim_seq_pkg::ST_PULL_X:
        next_state = sim_seq_pkg::ST_PULL_PCH;

      sim_seq_pkg::ST_PULL_PCH:
        next_state = sim_seq_pkg::ST_PULL_PCL;

      sim_seq_pkg::ST_PULL_PCL:
        next_state = sim_seq_pkg::ST_PREFETCH;

      sim_seq_pkg::ST_PREFETCH: begin
        if (chain_entry) begin
          next_state = sim_seq_pkg::ST_DUMMY;
        end else begin
          next_state = sim_seq_pkg::ST_IDLE;
        end
      end

      default:
        next_state = sim_seq_pkg::ST_IDLE;
    endcase
  end

  // Vector address follows the step: high byte, then low byte
  logic [sim_seq_pkg::VEC_W-1:0] vector_hi;
  logic [sim_seq_pkg::VEC_W-1:0] next_vector_addr;
  logic                          latch_grant;

  assign latch_grant = start_entry | chain_entry;
  assign next_vector_addr =
      (next_state == sim_seq_pkg::ST_VECT_HI) ? vector_hi :
      (next_state == sim_seq_pkg::ST_VECT_LO) ? vector_hi + 16'h0001 :
      vector_addr_o;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i | any_reset) begin
      state        <= sim_seq_pkg::ST_IDLE;
      bus_step_o   <= sim_seq_pkg::ST_IDLE;
      core_hold_o  <= 1'b0;
      fetch_next_o <= 1'b0;
      mask_set_o   <= 1'b0;
    end else begin
      state        <= next_state;
      bus_step_o   <= next_state;
      core_hold_o  <= (next_state != sim_seq_pkg::ST_IDLE);
      fetch_next_o <= next_fetch;
      mask_set_o   <= (state == sim_seq_pkg::ST_PUSH_CCR);
    end
  end

  // The granted source is held for the whole entry, so a request that
  // drops mid-sequence cannot change the vector fetched.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i | any_reset) begin
      vector_hi     <= '0;
      vector_addr_o <= '0;
      grant_src_o   <= '0;
    end else begin
      vector_addr_o <= next_vector_addr;
      if (latch_grant) begin
        vector_hi   <= cand_vector;
        grant_src_o <= cand_src;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      core_reset_o <= 1'b0;
      mask_clear_o <= 1'b0;
    end else begin
      core_reset_o <= any_reset;
      mask_clear_o <= lowpower_exec_i & ~any_reset;
    end
  end

  // ---------------------------------------------------------------
  // Event flags and interrupt
  // ---------------------------------------------------------------
  logic [sim_seq_pkg::NUM_EVT-1:0] evt_set;
  logic [sim_seq_pkg::NUM_EVT-1:0] evt_status;
  logic [sim_seq_pkg::NUM_EVT-1:0] evt_mask;
  logic                            evt_clr_wr;
  logic                            evt_mask_wr;
  logic                            irq_level;

  always_comb begin
    evt_set = '0;
    evt_set[sim_seq_pkg::EVT_ENTRY] = start_entry & ~any_reset;
    evt_set[sim_seq_pkg::EVT_CHAIN] = chain_entry & ~any_reset;
    evt_set[sim_seq_pkg::EVT_WAKE]  = lowpower_exec_i & ~any_reset;
    evt_set[sim_seq_pkg::EVT_RESET] = any_reset;
  end

  assign evt_clr_wr  = wr_en_i & (addr_i == sim_seq_pkg::ADDR_EVENT);
  assign evt_mask_wr = wr_en_i & (addr_i == sim_seq_pkg::ADDR_EVMASK);

  event_flags #(
    .N        (sim_seq_pkg::NUM_EVT),
    .MASK_RST (sim_seq_pkg::EVMASK_RST)
  ) u_events (
    .clk_i     (ref_clk_i),
    .rst_i     (sys_rst_i),
    .set_i     (evt_set),
    .clr_wr_i  (evt_clr_wr),
    .mask_wr_i (evt_mask_wr),
    .data_i    (wr_data_i[sim_seq_pkg::NUM_EVT-1:0]),
    .status_o  (evt_status),
    .mask_o    (evt_mask),
    .irq_o     (irq_level)
  );

  assign irq_o = irq_level;

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [sim_seq_pkg::DATA_W-1:0] status1_word;
  logic [sim_seq_pkg::DATA_W-1:0] status2_word;
  logic [sim_seq_pkg::DATA_W-1:0] status3_word;
  logic [sim_seq_pkg::DATA_W-1:0] read_word;

  // Flags show live requests, independent of enables or mask
  always_comb begin
    status1_word = sim_seq_pkg::READ_ZERO;
    status2_word = sim_seq_pkg::READ_ZERO;
    status3_word = sim_seq_pkg::READ_ZERO;
    status1_word[sim_seq_pkg::POS_SRC1] = irq_req_i[sim_seq_pkg::IDX_SRC1];
    status1_word[sim_seq_pkg::POS_SRC3] = irq_req_i[sim_seq_pkg::IDX_SRC3];
    status1_word[sim_seq_pkg::POS_SRC4] = irq_req_i[sim_seq_pkg::IDX_SRC4];
    status1_word[sim_seq_pkg::POS_SRC5] = irq_req_i[sim_seq_pkg::IDX_SRC5];
    status2_word[sim_seq_pkg::POS_SRC14] = irq_req_i[sim_seq_pkg::IDX_SRC14];
    status3_word[sim_seq_pkg::POS_SRC15] = irq_req_i[sim_seq_pkg::IDX_SRC15];
  end

  always_comb begin
    case (addr_i)
      sim_seq_pkg::ADDR_STATUS1:
        read_word = status1_word;

      sim_seq_pkg::ADDR_STATUS2:
        read_word = status2_word;

      sim_seq_pkg::ADDR_STATUS3:
        read_word = status3_word;

      sim_seq_pkg::ADDR_EVENT:
        read_word = {{(sim_seq_pkg::DATA_W - sim_seq_pkg::NUM_EVT){1'b0}}, evt_status};

      sim_seq_pkg::ADDR_EVMASK:
        read_word = {{(sim_seq_pkg::DATA_W - sim_seq_pkg::NUM_EVT){1'b0}}, evt_mask};

      default:
        read_word = sim_seq_pkg::READ_ZERO;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= sim_seq_pkg::READ_ZERO;
    end else if (rd_en_i) begin
      rd_data_o <= read_word;
    end else begin
      rd_data_o <= sim_seq_pkg::READ_ZERO;
    end
  end

endmodule : sim_interrupt_sequencer

//--- verif/sim_seq_properties.sv
/*
  Concurrent checks on the sequencer ports.
  Assumes one clock; bound from the bench top file.
*/
`timescale 1ns/10ps
module sim_seq_properties #(
  parameter int          RST_W      = 4,
  parameter logic [15:0] VECTOR_TOP = 16'hFFFE
) (
  input wire logic                       ref_clk_i,       // Clock
  input wire logic                       sys_rst_i,       // Reset
  input wire logic [2:0]                 addr_i,          // Address
  input wire logic                       rd_en_i,         // Read strobe
  input wire logic [7:0]                 rd_data_o,       // Read data
  input wire logic [5:0]                 irq_req_i,       // Requests
  input wire logic [5:0]                 irq_en_i,        // Enables
  input wire logic                       core_mask_i,     // Core mask
  input wire logic                       instr_done_i,    // Boundary
  input wire logic                       rti_exec_i,      // Return
  input wire logic                       lowpower_exec_i, // Wait or stop
  input wire logic [RST_W-1:0]           reset_src_i,     // Reset sources
  input wire logic                       core_reset_o,    // Core reset
  input wire logic                       core_hold_o,     // Busy
  input wire sim_seq_pkg::seq_state_type bus_step_o,      // Step
  input wire logic [15:0]                vector_addr_o,   // Vector address
  input wire logic [3:0]                 grant_src_o,     // Granted source
  input wire logic                       mask_set_o,      // Mask set
  input wire logic                       mask_clear_o,    // Mask clear
  input wire logic                       fetch_next_o     // Fetch next
);
  logic [5:0] pend;
  logic [3:0] want;
  logic       idle;
  logic       bnd;
  logic       take;
  logic [7:0] st1, st2, st3;
  logic [15:0] vhi;

  assign pend = irq_req_i & irq_en_i;
  assign idle = bus_step_o == sim_seq_pkg::ST_IDLE;
  assign bnd  = idle && instr_done_i && !rti_exec_i;
  assign take = !core_mask_i && (|pend);
  assign want = pend[0] ? 4'h1 : pend[1] ? 4'h3 : pend[2] ? 4'h4 :
                pend[3] ? 4'h5 : pend[4] ? 4'hE : 4'hF;
  assign st1  = {1'b0, irq_req_i[3:1], 1'b0, irq_req_i[0], 2'b00};
  assign st2  = {irq_req_i[4], 7'h00};
  assign st3  = {7'h00, irq_req_i[5]};
  assign vhi  = VECTOR_TOP - {11'h000, grant_src_o, 1'b0};

  // A reset source aborts any sequence, so it silences the sequence checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i || (|reset_src_i));

  hold_idle_a: assert property (
    idle && !instr_done_i && !rti_exec_i |=> idle) else $error("early start");
  take_entry_a: assert property (
    bnd && take |=> bus_step_o == sim_seq_pkg::ST_DUMMY && grant_src_o == $past(want))
    else $error("bad entry");
  decline_a: assert property (
    bnd && !take |=> idle && fetch_next_o) else $error("decline wrong");
  stack_order_a: assert property (
    bus_step_o == sim_seq_pkg::ST_DUMMY |=> bus_step_o == sim_seq_pkg::ST_PUSH_PCL ##1
    bus_step_o == sim_seq_pkg::ST_PUSH_PCH ##1 bus_step_o == sim_seq_pkg::ST_PUSH_X ##1
    bus_step_o == sim_seq_pkg::ST_PUSH_A ##1 bus_step_o == sim_seq_pkg::ST_PUSH_CCR ##1
    bus_step_o == sim_seq_pkg::ST_VECT_HI && mask_set_o) else $error("bad stacking");
  vector_pair_a: assert property (
    bus_step_o == sim_seq_pkg::ST_VECT_HI |-> vector_addr_o == vhi ##1
    bus_step_o == sim_seq_pkg::ST_VECT_LO && vector_addr_o == vhi + 16'h0001 ##1
    bus_step_o == sim_seq_pkg::ST_FETCH ##1 idle && !core_hold_o) else $error("vector wrong");
  return_seq_a: assert property (
    idle && rti_exec_i |=> bus_step_o == sim_seq_pkg::ST_PULL_CCR ##1
    bus_step_o == sim_seq_pkg::ST_PULL_A ##1 bus_step_o == sim_seq_pkg::ST_PULL_X ##1
    bus_step_o == sim_seq_pkg::ST_PULL_PCH ##1 bus_step_o == sim_seq_pkg::ST_PULL_PCL ##1
    bus_step_o == sim_seq_pkg::ST_PREFETCH) else $error("bad return");
  chain_a: assert property (
    bus_step_o == sim_seq_pkg::ST_PREFETCH && take |=> bus_step_o == sim_seq_pkg::ST_DUMMY
    && !fetch_next_o) else $error("chain missed");
  resume_a: assert property (
    bus_step_o == sim_seq_pkg::ST_PREFETCH && !take |=> idle && fetch_next_o)
    else $error("resume wrong");
  status1_a: assert property (disable iff (sys_rst_i)
    rd_en_i && addr_i == sim_seq_pkg::ADDR_STATUS1 |=> rd_data_o == $past(st1))
    else $error("status one wrong");
  status2_a: assert property (disable iff (sys_rst_i)
    rd_en_i && addr_i == sim_seq_pkg::ADDR_STATUS2 |=> rd_data_o == $past(st2))
    else $error("status two wrong");
  status3_a: assert property (disable iff (sys_rst_i)
    rd_en_i && addr_i == sim_seq_pkg::ADDR_STATUS3 |=> rd_data_o == $past(st3))
    else $error("status three wrong");
  reset_src_a: assert property (disable iff (sys_rst_i)
    |reset_src_i |=> core_reset_o && idle && !core_hold_o) else $error("reset source ignored");
  lowpower_a: assert property (
    lowpower_exec_i |=> mask_clear_o) else $error("mask not cleared");
endmodule : sim_seq_properties

//--- verif/core_model.sv
/*
  Behavioural processor core: turns bench commands into boundary, return
  and low-power pulses and tracks its own interrupt mask.
  Assumes commands only while the sequencer is idle.
*/
`timescale 1ns/10ps
module core_model (
  input  wire logic                       ref_clk_i,    // Clock
  input  wire logic                       sys_rst_i,    // Reset
  input  wire logic                       op_v_i,       // Command valid
  input  wire logic [2:0]                 op_i,         // 1 instr 2 ret 3 wait 4 sei 5 cli
  input  wire logic                       mask_set_i,   // Entry sets mask
  input  wire logic                       mask_clear_i, // Low power clears
  input  wire sim_seq_pkg::seq_state_type bus_step_i,   // Sequencer step
  output logic                            core_mask_o,  // Mask bit
  output logic                            done_o,       // Boundary pulse
  output logic                            rti_o,        // Return pulse
  output logic                            lp_o          // Low power pulse
);
  always_ff @(posedge ref_clk_i) begin
    done_o <= !sys_rst_i && op_v_i && op_i == 3'd1;
    rti_o  <= !sys_rst_i && op_v_i && op_i == 3'd2;
    lp_o   <= !sys_rst_i && op_v_i && op_i == 3'd3;
    if (sys_rst_i || mask_set_i || (op_v_i && op_i == 3'd4)) begin
      core_mask_o <= 1'b1;
    end else if (mask_clear_i || (op_v_i && op_i == 3'd5) ||
                 bus_step_i == sim_seq_pkg::ST_PULL_CCR) begin
      core_mask_o <= 1'b0;
    end
  end
endmodule : core_model

//--- verif/tb.sv
/*
  Self-checking bench, one task per scenario.
  Assumes package, design, checker and core model compiled first.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [15:0] VTOP = 16'hFFFE;
  logic        ref_clk_i, sys_rst_i, wr_en_i, rd_en_i, op_v;
  logic [2:0]  addr_i, op;
  logic [7:0]  wr_data_i, rd_data_o, d;
  logic [5:0]  irq_req_i, irq_en_i;
  logic [3:0]  reset_src_i, grant_src_o;
  logic        core_mask_i, instr_done_i, rti_exec_i, lowpower_exec_i, core_reset_o;
  logic        core_hold_o, mask_set_o, mask_clear_o, fetch_next_o, irq_o;
  logic [15:0] vector_addr_o;
  logic [3:0]  num [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'hE, 4'hF};
  int          num_errors = 0;
  int          checks     = 0;
  sim_seq_pkg::seq_state_type bus_step_o;

  sim_interrupt_sequencer #(.RST_W(4), .VECTOR_TOP(VTOP)) i_dut (.*);
  core_model i_core (
    .ref_clk_i, .sys_rst_i, .op_v_i(op_v), .op_i(op), .mask_set_i(mask_set_o),
    .mask_clear_i(mask_clear_o), .bus_step_i(bus_step_o), .core_mask_o(core_mask_i),
    .done_o(instr_done_i), .rti_o(rti_exec_i), .lp_o(lowpower_exec_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ---------
  // Helpers
  // ---------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i    <= a;
    wr_data_i <= v;
    wr_en_i   <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1 v = rd_data_o;
  endtask : rd

  task automatic core_op(input logic [2:0] o);
    @(posedge ref_clk_i);
    op   <= o;
    op_v <= 1'b1;
    @(posedge ref_clk_i);
    op_v <= 1'b0;
  endtask : core_op

  // -----------
  // Scenarios
  // -----------
  task automatic t_status;
    logic [5:0] r;
    for (int i = 0; i < 6; i++) begin
      r = 6'h01 << i;
      irq_req_i <= r;
      wr(sim_seq_pkg::ADDR_STATUS1, 8'hFF);
      rd(sim_seq_pkg::ADDR_STATUS1, d);
      cmp(d, {1'b0, r[3:1], 1'b0, r[0], 2'b00}, "status one");
      rd(sim_seq_pkg::ADDR_STATUS2, d);
      cmp(d, {r[4], 7'h00}, "status two");
      rd(sim_seq_pkg::ADDR_STATUS3, d);
      cmp(d, {7'h00, r[5]}, "status three");
    end
    rd(3'h7, d);
    cmp(d, 8'h00, "unmapped read");
  endtask : t_status

  task automatic t_decline;
    irq_req_i <= 6'h01;
    irq_en_i  <= 6'h3E;
    core_op(3'd1);
    tick(1);
    cmp(fetch_next_o, 1'b1, "disabled source");
    irq_en_i <= 6'h3F;
    core_op(3'd4);
    core_op(3'd1);
    tick(1);
    cmp(fetch_next_o, 1'b1, "masked core");
    wr(sim_seq_pkg::ADDR_EVMASK, 8'h00);
    core_op(3'd3);
    tick(1);
    cmp(mask_clear_o, 1'b1, "low power");
    tick(2);
    cmp(irq_o, 1'b0, "event masked");
    wr(sim_seq_pkg::ADDR_EVMASK, 8'h04);
    tick(2);
    cmp(irq_o, 1'b1, "event raised");
    wr(sim_seq_pkg::ADDR_EVENT, 8'h04);
    tick(2);
    cmp(irq_o, 1'b0, "event cleared");
  endtask : t_decline

  task automatic t_prio;
    for (int i = 0; i < 6; i++) begin
      irq_req_i <= 6'h3F << i;
      tick(3);
      cmp(bus_step_o, sim_seq_pkg::ST_IDLE, "no boundary");
      core_op(3'd1);
      tick(1);
      cmp(bus_step_o, sim_seq_pkg::ST_DUMMY, "entry");
      cmp(grant_src_o, num[i], "winner");
      tick(6);
      cmp(bus_step_o, sim_seq_pkg::ST_VECT_HI, "vector step");
      cmp(vector_addr_o, VTOP - {11'h000, num[i], 1'b0}, "vector");
      irq_req_i <= 6'h00;
      tick(3);
      core_op(3'd2);
      tick(7);
      cmp(fetch_next_o, 1'b1, "resume");
    end
  endtask : t_prio

  task automatic t_chain;
    wr(sim_seq_pkg::ADDR_EVENT, 8'h0F);
    irq_req_i <= 6'h03;
    core_op(3'd1);
    tick(10);
    irq_req_i <= 6'h02;
    core_op(3'd2);
    tick(6);
    cmp(bus_step_o, sim_seq_pkg::ST_PREFETCH, "redundant prefetch");
    tick(1);
    cmp(bus_step_o, sim_seq_pkg::ST_DUMMY, "chained entry");
    cmp(grant_src_o, 4'h3, "chained source");
    cmp(fetch_next_o, 1'b0, "no fetch");
    irq_req_i <= 6'h00;
    tick(9);
    rd(sim_seq_pkg::ADDR_EVENT, d);
    cmp(d, 8'h03, "entry events");
    core_op(3'd2);
    tick(7);
  endtask : t_chain

  task automatic t_reset;
    irq_req_i <= 6'h01;
    for (int b = 0; b < 4; b++) begin
      core_op(3'd1);
      tick(3);
      reset_src_i <= 4'h1 << b;
      tick(1);
      cmp(core_reset_o, 1'b1, "reset source");
      cmp(bus_step_o, sim_seq_pkg::ST_IDLE, "sequence dropped");
      reset_src_i <= 4'h0;
      tick(1);
    end
    irq_req_i <= 6'h00;
  endtask : t_reset

  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    sys_rst_i   = 1'b1;
    wr_en_i     = 1'b0;
    rd_en_i     = 1'b0;
    op_v        = 1'b0;
    op          = 3'd0;
    addr_i      = 3'h0;
    wr_data_i   = 8'h00;
    irq_req_i   = 6'h00;
    irq_en_i    = 6'h00;
    reset_src_i = 4'h0;
    tick(5);
    sys_rst_i <= 1'b0;
    tick(1);
    cmp(bus_step_o, sim_seq_pkg::ST_IDLE, "reset step");
    core_op(3'd5);
    t_status;
    t_decline;
    t_prio;
    t_chain;
    t_reset;
    close_out;
  end

  // The scenarios need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    num_errors++;
    close_out;
  end
endmodule : tb

bind sim_interrupt_sequencer sim_seq_properties
  #(.RST_W(RST_W), .VECTOR_TOP(VECTOR_TOP)) u_props (.*);
